// *** rtl/fsx_pkg.sv ***
// shared types and constants for the fp issue scheduler
package fsx_pkg;

	typedef enum logic [4:0] {
		OP_NOP     = 5'h00,
		OP_ADD     = 5'h01,
		OP_MUL     = 5'h02,
		OP_DIV     = 5'h03,
		OP_SQRT    = 5'h04,
		OP_CVT     = 5'h05,
		OP_NEGABS  = 5'h06,
		OP_MOV     = 5'h07,
		OP_CMP     = 5'h08,
		OP_LOAD    = 5'h09,
		OP_STORE   = 5'h0A,
		OP_TO_FP   = 5'h0B,
		OP_FROM_FP = 5'h0C,
		OP_CTL_WR  = 5'h0D,
		OP_CTL_RD  = 5'h0E,
		OP_BRANCH  = 5'h0F
	} fsx_op_t;

	// minimum latencies in pipeline cycles
	localparam logic [5:0] LAT_ADD    = 6'h04;
	localparam logic [5:0] LAT_MUL    = 6'h08;
	localparam logic [5:0] LAT_DIV    = 6'h20;
	localparam logic [5:0] LAT_SQRT   = 6'h1F;
	localparam logic [5:0] LAT_ONE    = 6'h01;
	localparam logic [5:0] LAT_CVT    = 6'h04;
	localparam logic [5:0] LAT_CMP    = 6'h03;
	localparam logic [5:0] LAT_LOAD   = 6'h02;
	localparam logic [5:0] LAT_STORE  = 6'h01;
	localparam logic [5:0] LAT_MOVE   = 6'h02;
	localparam logic [5:0] LAT_CTL_WR = 6'h03;
	localparam logic [5:0] LAT_CTL_RD = 6'h02;
	localparam logic [5:0] LAT_BRANCH = 6'h01;

	// multiplier spacing
	localparam logic [5:0] MUL_REISSUE   = 6'h06;
	localparam logic [5:0] ADD_AFTER_MUL = 6'h02;
	localparam logic [5:0] AGE_MAX       = 6'h3F;

	// exception bit positions in cause, enable and flag vectors
	localparam int EXC_I = 0;
	localparam int EXC_U = 1;
	localparam int EXC_O = 2;
	localparam int EXC_Z = 3;
	localparam int EXC_V = 4;
	localparam int EXC_E = 5;

	// system exception code for a coprocessor fault, plain default
	localparam logic [4:0] FPE_CODE = 5'h0F;

	// byte lane holding the lowest-addressed byte
	localparam logic [1:0] LANE_BIG    = 2'h3;
	localparam logic [1:0] LANE_LITTLE = 2'h0;

	// compare predicate bit positions
	localparam int CND_UN  = 0;
	localparam int CND_EQ  = 1;
	localparam int CND_LT  = 2;
	localparam int CND_SIG = 3;

	typedef struct packed {
		logic       valid;
		fsx_op_t    op;
		logic       dbl;
		logic       word_fmt;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] dst;
		logic       rd_a;
		logic       rd_b;
		logic [2:0] addr_lo;
		logic [3:0] cond;
	} fsx_iss_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] ieee;
		logic       unimpl;
	} fsx_exc_t;

	typedef struct packed {
		logic res;
		logic inv;
	} fsx_cmp_st_t;

	typedef struct packed {
		logic        ack;
		logic        stall;
		logic        start;
		fsx_op_t     start_op;
		logic [5:0]  add_rem;
		logic [5:0]  mul_rem;
		logic [5:0]  mul_age;
		logic [5:0]  pend_rem;
		logic [4:0]  pend_reg;
		logic        add_cmp;
		logic        wb_valid;
		logic [4:0]  wb_reg;
		logic        cond;
		logic        trap;
		logic [5:0]  cause;
		logic [4:0]  flags;
		logic        addr_err;
		logic        commit;
		logic        qnan;
		logic [1:0]  first_lane;
		logic [31:0] move_data;
	} fsx_state_t;

endpackage

// *** rtl/fsx_cmp.sv ***
// compare unit: evaluates the condition predicate on two operands
`timescale 1ns/1ps
module fsx_cmp (
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_go,
	input  wire logic [31:0] i_a,
	input  wire logic [31:0] i_b,
	input  wire logic [3:0]  i_cond,
	input  wire logic        i_word,
	output logic             o_res,
	output logic             o_inv
);
	fsx_pkg::fsx_cmp_st_t s;
	fsx_pkg::fsx_cmp_st_t next_s;

	function automatic logic is_nan(input logic [31:0] v);
		return (&v[30:23]) && (|v[22:0]);
	endfunction

	function automatic logic [31:0] order_key(input logic [31:0] v);
		return v[31] ? ~v : (v | 32'h80000000);
	endfunction

	always_comb begin
		logic unord;
		logic sig_src;
		logic zeros;
		logic lt;
		logic eq;
		unord   = 1'b0;
		sig_src = 1'b0;
		zeros   = 1'b0;
		lt      = 1'b0;
		eq      = 1'b0;
		next_s  = s;
		if (i_word) begin
			lt = $signed(i_a) < $signed(i_b);
			eq = i_a == i_b;
		end else begin
			unord   = is_nan(i_a) || is_nan(i_b);
			sig_src = (is_nan(i_a) && i_a[22]) || (is_nan(i_b) && i_b[22]);
			zeros   = (i_a[30:0] == 31'h0) && (i_b[30:0] == 31'h0);
			lt = !unord && !zeros && (order_key(i_a) < order_key(i_b));
			eq = !unord && (zeros || i_a == i_b);
		end
		if (i_go) begin
			// predicate is the or of the selected relations
			next_s.res = (i_cond[fsx_pkg::CND_LT] && lt)
				|| (i_cond[fsx_pkg::CND_EQ] && eq)
				|| (i_cond[fsx_pkg::CND_UN] && unord);
			next_s.inv = unord && (i_cond[fsx_pkg::CND_SIG] || sig_src);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_res = s.res;
	assign o_inv = s.inv;

	cmp_unord_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_go && !i_word && (&i_a[30:23]) && (|i_a[22:0])
		|=> o_res == $past(i_cond[fsx_pkg::CND_UN]))
		else $error("unordered compare result wrong");
endmodule // fsx_cmp

// *** rtl/fsx_sched.sv ***
// fp coprocessor issue scheduler, interlocks and exception control
// Contract
// - word moves copy bits unchanged and never raise an fp exception
// - read of a just-loaded register stalls until the load completes
// - address selects lowest-addressed byte, leftmost big or rightmost little
// - compare reads two registers in format and sets condition bit
// - sixteen predicates from unordered, equal, less and signaling bits
// - single and word compares run, double compares trap
// - five-stage pipeline stalls whole on register or unit conflict
// - fp ops never overlap except add under mul and mul after mul
// - add may begin two cycles after a multiply starts
// - multiplier accepts a new multiply at most every six cycles
// - arithmetic latencies add 4, mul 8, div 32, sqrt 31, others listed
// - transfer latencies load 2, store 1, moves 2, control 3/2, branch 1
// - double or 64-bit fixed operations trap as unimplemented
// - divide starts only with adder and multiplier idle
// - multiply needs idle adder and multiplier idle or six cycles old
// - add needs idle adder and multiplier idle or two cycles old
// - sqrt, convert, negate, abs, compare need both units idle
// - unmet start conditions interlock issue until met
// - trap keeps destination unchanged, else default result and continue
// - exception sets cause; disabled sets flag, enabled traps
// - unimplemented exception has no enable or flag and always traps
// - trap reports fp exception code with cause bits as reason
// - flags stay set until software writes them
// - disabled underflow traps unimplemented unless flush tiny set
// - disabled invalid delivers a quiet nan
`timescale 1ns/1ps
module fsx_sched (
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	input  wire fsx_pkg::fsx_iss_t i_iss,
	input  wire logic [31:0]       i_move_data,
	input  wire logic [31:0]       i_cmp_a,
	input  wire logic [31:0]       i_cmp_b,
	input  wire fsx_pkg::fsx_exc_t i_exc,
	input  wire logic [4:0]        i_enable,
	input  wire logic              i_flush_tiny_results,
	input  wire logic              i_big_endian,
	input  wire logic              i_flag_wr,
	input  wire logic [4:0]        i_flag_data,
	output logic                   o_ack,
	output logic                   o_stall,
	output logic                   o_start,
	output fsx_pkg::fsx_op_t       o_start_op,
	output logic                   o_wb_valid,
	output logic [4:0]             o_wb_reg,
	output logic                   o_cond,
	output logic                   o_trap,
	output logic [4:0]             o_fp_exception_code,
	output logic [5:0]             o_cause,
	output logic [4:0]             o_flags,
	output logic                   o_addr_err,
	output logic                   o_commit,
	output logic                   o_qnan,
	output logic [1:0]             o_first_lane,
	output logic [31:0]            o_move_data
);
	fsx_pkg::fsx_state_t s;
	fsx_pkg::fsx_state_t next_s;
	logic                cmp_go;
	logic                cmp_res;
	logic                cmp_inv;

	// cycles the op occupies its unit or its destination
	function automatic logic [5:0] op_lat(input fsx_pkg::fsx_op_t op);
		unique case (op)
			fsx_pkg::OP_ADD:     return fsx_pkg::LAT_ADD;
			fsx_pkg::OP_MUL:     return fsx_pkg::LAT_MUL;
			fsx_pkg::OP_DIV:     return fsx_pkg::LAT_DIV;
			fsx_pkg::OP_SQRT:    return fsx_pkg::LAT_SQRT;
			fsx_pkg::OP_CVT:     return fsx_pkg::LAT_CVT;
			fsx_pkg::OP_CMP:     return fsx_pkg::LAT_CMP;
			fsx_pkg::OP_LOAD:    return fsx_pkg::LAT_LOAD;
			fsx_pkg::OP_STORE:   return fsx_pkg::LAT_STORE;
			fsx_pkg::OP_TO_FP,
			fsx_pkg::OP_FROM_FP: return fsx_pkg::LAT_MOVE;
			fsx_pkg::OP_CTL_WR:  return fsx_pkg::LAT_CTL_WR;
			fsx_pkg::OP_CTL_RD:  return fsx_pkg::LAT_CTL_RD;
			fsx_pkg::OP_BRANCH:  return fsx_pkg::LAT_BRANCH;
			default:             return fsx_pkg::LAT_ONE;
		endcase
	endfunction

	function automatic logic [5:0] dec(input logic [5:0] v);
		return (v == 6'h00) ? 6'h00 : v - 6'h01;
	endfunction

	function automatic logic is_mem(input fsx_pkg::fsx_op_t op);
		return op == fsx_pkg::OP_LOAD || op == fsx_pkg::OP_STORE;
	endfunction

	function automatic logic on_adder(input fsx_pkg::fsx_op_t op);
		return op inside {fsx_pkg::OP_ADD, fsx_pkg::OP_DIV, fsx_pkg::OP_SQRT,
			fsx_pkg::OP_CVT, fsx_pkg::OP_NEGABS, fsx_pkg::OP_MOV,
			fsx_pkg::OP_CMP};
	endfunction

	function automatic logic writes_fp(input fsx_pkg::fsx_op_t op);
		return on_adder(op) && op != fsx_pkg::OP_CMP
			|| op inside {fsx_pkg::OP_MUL, fsx_pkg::OP_LOAD,
			fsx_pkg::OP_TO_FP};
	endfunction

	always_comb begin
		logic       add_idle;
		logic       mul_idle;
		logic       unit_ok;
		logic       raw;
		logic       req;
		logic       misalign;
		logic       cmp_done;
		logic [4:0] ev;
		logic       unimpl;
		logic       trapping;
		next_s   = s;
		cmp_go   = 1'b0;
		add_idle = s.add_rem == 6'h00;
		mul_idle = s.mul_rem == 6'h00;
		unit_ok  = 1'b1;
		raw      = 1'b0;
		misalign = 1'b0;
		req      = i_iss.valid && !s.ack;
		cmp_done = s.add_cmp && s.add_rem == 6'h01;
		ev       = '0;
		unimpl   = 1'b0;
		trapping = 1'b0;

		next_s.ack      = 1'b0;
		next_s.stall    = 1'b0;
		next_s.start    = 1'b0;
		next_s.trap     = 1'b0;
		next_s.addr_err = 1'b0;
		next_s.commit   = 1'b0;
		next_s.qnan     = 1'b0;
		next_s.wb_valid = 1'b0;
		next_s.add_rem  = dec(s.add_rem);
		next_s.mul_rem  = dec(s.mul_rem);
		next_s.pend_rem = dec(s.pend_rem);
		if (!mul_idle && s.mul_age != fsx_pkg::AGE_MAX) begin
			next_s.mul_age = s.mul_age + 6'h01;
		end
		if (s.pend_rem == 6'h01) begin
			next_s.wb_valid = 1'b1;
			next_s.wb_reg   = s.pend_reg;
		end
		if (cmp_done) begin
			next_s.cond    = cmp_res;
			next_s.add_cmp = 1'b0;
		end

		// unit start conditions
		unique case (i_iss.op)
			fsx_pkg::OP_MUL: unit_ok = add_idle && (mul_idle
				|| s.mul_age >= fsx_pkg::MUL_REISSUE);
			fsx_pkg::OP_ADD: unit_ok = add_idle && (mul_idle
				|| s.mul_age >= fsx_pkg::ADD_AFTER_MUL);
			fsx_pkg::OP_DIV: unit_ok = add_idle && mul_idle;
			fsx_pkg::OP_SQRT, fsx_pkg::OP_CVT, fsx_pkg::OP_NEGABS,
			fsx_pkg::OP_MOV, fsx_pkg::OP_CMP:
				unit_ok = add_idle && mul_idle;
			fsx_pkg::OP_BRANCH: unit_ok = !s.add_cmp;
			default: unit_ok = 1'b1;
		endcase
		raw = s.pend_rem > 6'h01 && ((i_iss.rd_a && i_iss.src_a == s.pend_reg)
			|| (i_iss.rd_b && i_iss.src_b == s.pend_reg));
		misalign = is_mem(i_iss.op) && (i_iss.dbl ? i_iss.addr_lo != 3'h0
			: i_iss.addr_lo[1:0] != 2'h0);

		if (req) begin
			if (misalign) begin
				next_s.ack      = 1'b1;
				next_s.addr_err = 1'b1;
			end else if (i_iss.dbl) begin
				// no unit starts, destination untouched
				next_s.ack   = 1'b1;
				next_s.trap  = 1'b1;
				next_s.cause = 6'h20;
			end else if (unit_ok && !raw) begin
				next_s.ack      = 1'b1;
				next_s.start    = 1'b1;
				next_s.start_op = i_iss.op;
				if (on_adder(i_iss.op)) begin
					next_s.add_rem = op_lat(i_iss.op);
					next_s.add_cmp = i_iss.op == fsx_pkg::OP_CMP;
					cmp_go         = i_iss.op == fsx_pkg::OP_CMP;
				end
				if (i_iss.op == fsx_pkg::OP_MUL) begin
					next_s.mul_rem = fsx_pkg::LAT_MUL;
					next_s.mul_age = 6'h00;
				end
				if (writes_fp(i_iss.op)) begin
					next_s.pend_rem = op_lat(i_iss.op);
					next_s.pend_reg = i_iss.dst;
				end
				if (is_mem(i_iss.op)) begin
					next_s.first_lane = i_big_endian ? fsx_pkg::LANE_BIG
						: fsx_pkg::LANE_LITTLE;
				end
				if (i_iss.op == fsx_pkg::OP_TO_FP
					|| i_iss.op == fsx_pkg::OP_FROM_FP) begin
					next_s.move_data = i_move_data;
				end
			end else begin
				next_s.stall = 1'b1;
			end
		end

		// exception resolution at completion
		if (i_exc.valid || (cmp_done && cmp_inv)) begin
			ev = i_exc.valid ? i_exc.ieee : 5'h00;
			ev[fsx_pkg::EXC_V] = ev[fsx_pkg::EXC_V] || (cmp_done && cmp_inv);
			unimpl = (i_exc.valid && i_exc.unimpl)
				|| (ev[fsx_pkg::EXC_U] && !i_enable[fsx_pkg::EXC_U]
				&& !i_flush_tiny_results);
			trapping = unimpl || |(ev & i_enable);
			next_s.cause = {unimpl, ev};
			next_s.trap  = trapping;
			next_s.commit = !trapping;
			next_s.qnan = !trapping && ev[fsx_pkg::EXC_V];
		end

		// sticky flags, hardware set wins over software write
		next_s.flags = (i_flag_wr ? i_flag_data : s.flags)
			| ((trapping || unimpl) ? 5'h00 : (ev & ~i_enable));
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	fsx_cmp u_cmp (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_go      (cmp_go),
		.i_a       (i_cmp_a),
		.i_b       (i_cmp_b),
		.i_cond    (i_iss.cond),
		.i_word    (i_iss.word_fmt),
		.o_res     (cmp_res),
		.o_inv     (cmp_inv)
	);

	assign o_ack               = s.ack;
	assign o_stall             = s.stall;
	assign o_start             = s.start;
	assign o_start_op          = s.start_op;
	assign o_wb_valid          = s.wb_valid;
	assign o_wb_reg            = s.wb_reg;
	assign o_cond              = s.cond;
	assign o_trap              = s.trap;
	assign o_fp_exception_code = fsx_pkg::FPE_CODE;
	assign o_cause             = s.cause;
	assign o_flags             = s.flags;
	assign o_addr_err          = s.addr_err;
	assign o_commit            = s.commit;
	assign o_qnan              = s.qnan;
	assign o_first_lane        = s.first_lane;
	assign o_move_data         = s.move_data;

	sequence add_busy_s;
		(s.add_rem != 6'h00) [*4];
	endsequence

	mul_spacing_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		s.start && s.start_op == fsx_pkg::OP_MUL |->
		$past(s.mul_rem) == 6'h00 || $past(s.mul_age) >= 6'h06)
		else $error("multiply issued too soon");
	add_after_mul_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		s.start && s.start_op == fsx_pkg::OP_ADD |->
		$past(s.add_rem) == 6'h00 && ($past(s.mul_rem) == 6'h00
		|| $past(s.mul_age) >= 6'h02))
		else $error("add issued into busy units");
	div_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		s.start && s.start_op == fsx_pkg::OP_DIV |->
		$past(s.add_rem) == 6'h00 && $past(s.mul_rem) == 6'h00)
		else $error("divide issued into busy units");
	add_latency_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		s.start && s.start_op == fsx_pkg::OP_ADD |-> (add_busy_s ##1
		s.add_rem == 6'h00))
		else $error("add occupancy not four cycles");
	dbl_trap_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_iss.valid && !s.ack && i_iss.dbl && !is_mem(i_iss.op) && !i_exc.valid
		&& !s.add_cmp |=> s.trap && s.cause[fsx_pkg::EXC_E] && !s.start)
		else $error("double op did not trap");
	misalign_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_iss.valid && !s.ack && i_iss.op == fsx_pkg::OP_LOAD
		&& i_iss.addr_lo[1:0] != 2'h0 |=> s.addr_err && !s.start)
		else $error("misaligned load accepted");
	load_use_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_iss.valid && !s.ack && i_iss.rd_a && i_iss.src_a == s.pend_reg
		&& s.pend_rem > 6'h01 |=> !s.start)
		else $error("pending register read not interlocked");
	flag_sticky_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		!i_flag_wr |=> ($past(s.flags) & ~s.flags) == 5'h00)
		else $error("flag dropped without write");
	underflow_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_exc.valid && i_exc.ieee[fsx_pkg::EXC_U] && !i_enable[fsx_pkg::EXC_U]
		&& !i_flush_tiny_results |=> s.trap && s.cause[fsx_pkg::EXC_E]
		&& !s.flags[fsx_pkg::EXC_U] || $past(s.flags[fsx_pkg::EXC_U])
		|| $past(i_flag_wr))
		else $error("untrapped underflow missed");
	move_copy_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		s.start && s.start_op inside {fsx_pkg::OP_TO_FP, fsx_pkg::OP_FROM_FP}
		|-> s.move_data == $past(i_move_data) && s.cause == $past(s.cause)
		|| $past(i_exc.valid) || $past(s.add_cmp))
		else $error("move altered data");
endmodule // fsx_sched

// *** dv/fsx_cpu_model.sv ***
// behavioural integer pipeline issuing requests to the fp scheduler
`timescale 1ns/1ps
module fsx_cpu_model (
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_go,
	input  wire fsx_pkg::fsx_iss_t i_cmd,
	input  wire logic              i_ack,
	output fsx_pkg::fsx_iss_t      o_iss
);
	fsx_pkg::fsx_iss_t q[$];

	// request held until ack; next queued one follows at once
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q.delete();
			o_iss <= '0;
		end else begin
			if (i_go)
				q.push_back(i_cmd);
			if (!o_iss.valid || i_ack) begin
				// addresses passed as given, misaligned only on request
				if (q.size() > 0)
					o_iss <= q.pop_front();
				else
					o_iss <= {1'b0, ~o_iss[$bits(o_iss)-2:0]};
			end
		end
	end
endmodule // fsx_cpu_model

// *** dv/tb_fsx_sched.sv ***
// self-checking bench for the fp issue scheduler
`timescale 1ns/1ps
module tb_fsx_sched;
	logic              i_sys_clk = 1'b0;
	logic              i_arst_n;
	logic              go;
	fsx_pkg::fsx_iss_t cmd;
	fsx_pkg::fsx_iss_t iss;
	logic [31:0]       mv_d, cmp_a, cmp_b, o_move_data;
	fsx_pkg::fsx_exc_t exc;
	logic [4:0]        enable, flag_d, o_fpe, o_flags, o_wb_reg;
	logic              flush, big, flag_wr;
	logic              o_ack, o_stall, o_start, o_wb_valid, o_cond;
	logic              o_trap, o_addr_err, o_commit, o_qnan;
	fsx_pkg::fsx_op_t  o_start_op;
	logic [5:0]        o_cause, a_cause;
	logic [1:0]        o_lane, a_lane;
	logic              a_trap, a_aerr, stall_seen = 1'b0;
	int                err_total = 0, checks_done = 0, cyc = 0, acks = 0;
	int                st_cyc = 0, st_prev = 0, wb_cyc = 0;

	always #5 i_sys_clk = ~i_sys_clk;

	fsx_sched u_fsx_sched (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
		.i_iss(iss), .i_move_data(mv_d), .i_cmp_a(cmp_a), .i_cmp_b(cmp_b),
		.i_exc(exc), .i_enable(enable), .i_flush_tiny_results(flush),
		.i_big_endian(big), .i_flag_wr(flag_wr), .i_flag_data(flag_d),
		.o_ack(o_ack), .o_stall(o_stall), .o_start(o_start),
		.o_start_op(o_start_op), .o_wb_valid(o_wb_valid),
		.o_wb_reg(o_wb_reg), .o_cond(o_cond), .o_trap(o_trap),
		.o_fp_exception_code(o_fpe), .o_cause(o_cause), .o_flags(o_flags),
		.o_addr_err(o_addr_err), .o_commit(o_commit), .o_qnan(o_qnan),
		.o_first_lane(o_lane), .o_move_data(o_move_data));

	fsx_cpu_model u_fsx_cpu_model (.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n), .i_go(go), .i_cmd(cmd), .i_ack(o_ack),
		.o_iss(iss));

	// pulse capture and timing of starts and results
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (o_start === 1'b1) begin
			st_prev <= st_cyc;
			st_cyc <= cyc;
		end
		if (o_wb_valid === 1'b1)
			wb_cyc <= cyc;
		if (o_stall === 1'b1)
			stall_seen <= 1'b1;
		if (o_ack === 1'b1) begin
			acks <= acks + 1;
			a_trap <= o_trap;
			a_aerr <= o_addr_err;
			a_cause <= o_cause;
			a_lane <= o_lane;
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic fsx_pkg::fsx_iss_t mk(fsx_pkg::fsx_op_t op,
		logic dbl, logic [4:0] dst, logic [4:0] src, logic [2:0] adr,
		logic [3:0] cnd);
		mk = '0;
		mk.valid = 1'b1;
		mk.op = op;
		mk.dbl = dbl;
		mk.dst = dst;
		mk.src_a = src;
		mk.rd_a = (src != 5'h00);
		mk.addr_lo = adr;
		mk.cond = cnd;
	endfunction

	task automatic wait_acks(input int t);
		int k;
		k = 0;
		while (acks < t && k < 400) begin
			@(posedge i_sys_clk);
			k++;
		end
		if (acks < t) begin
			err_total++;
			$display("[FAIL] ack count expected %0d seen %0d", t, acks);
			report_and_stop();
		end
	endtask

	task automatic run(input fsx_pkg::fsx_iss_t c);
		int n;
		n = acks;
		cmd <= c;
		go <= 1'b1;
		@(posedge i_sys_clk);
		go <= 1'b0;
		wait_acks(n + 1);
	endtask

	task automatic run2(input fsx_pkg::fsx_iss_t c1, c2);
		int n;
		n = acks;
		stall_seen <= 1'b0;
		cmd <= c1;
		go <= 1'b1;
		@(posedge i_sys_clk);
		cmd <= c2;
		@(posedge i_sys_clk);
		go <= 1'b0;
		wait_acks(n + 2);
	endtask

	task automatic t_lat();
		fsx_pkg::fsx_op_t ops[4] = '{fsx_pkg::OP_ADD, fsx_pkg::OP_MUL,
			fsx_pkg::OP_DIV, fsx_pkg::OP_LOAD};
		logic [5:0] lat[4] = '{fsx_pkg::LAT_ADD, fsx_pkg::LAT_MUL,
			fsx_pkg::LAT_DIV, fsx_pkg::LAT_LOAD};
		for (int i = 0; i < 4; i++) begin
			run(mk(ops[i], 1'b0, 5'h01, 5'h00, 3'h0, 4'h0));
			repeat (int'(lat[i]) + 4) @(posedge i_sys_clk);
			check("result latency", 32'(wb_cyc - st_cyc),
				32'(lat[i]));
		end
	endtask

	task automatic t_pair();
		run2(mk(fsx_pkg::OP_MUL, 1'b0, 5'h01, 5'h00, 3'h0, 4'h0),
			mk(fsx_pkg::OP_ADD, 1'b0, 5'h02, 5'h00, 3'h0, 4'h0));
		check("add after mul", 32'(st_cyc - st_prev >= 2), 32'h1);
		check("add under mul", 32'(st_cyc - st_prev < 8), 32'h1);
		repeat (20) @(posedge i_sys_clk);
		run2(mk(fsx_pkg::OP_MUL, 1'b0, 5'h01, 5'h00, 3'h0, 4'h0),
			mk(fsx_pkg::OP_MUL, 1'b0, 5'h02, 5'h00, 3'h0, 4'h0));
		check("mul spacing", 32'(st_cyc - st_prev >= 6), 32'h1);
		check("mul interlock", 32'(stall_seen), 32'h1);
		repeat (20) @(posedge i_sys_clk);
	endtask

	task automatic t_dbl();
		fsx_pkg::fsx_op_t ops[4] = '{fsx_pkg::OP_ADD, fsx_pkg::OP_CMP,
			fsx_pkg::OP_CVT, fsx_pkg::OP_TO_FP};
		for (int i = 0; i < 4; i++) begin
			run(mk(ops[i], 1'b1, 5'h01, 5'h00, 3'h0, 4'h0));
			check("double trap", 32'(a_trap), 32'h1);
			check("double cause", 32'(a_cause), 32'h20);
		end
		check("exception code", 32'(o_fpe), 32'h0F);
	endtask

	task automatic t_align();
		fsx_pkg::fsx_op_t ops[4] = '{fsx_pkg::OP_LOAD, fsx_pkg::OP_STORE,
			fsx_pkg::OP_LOAD, fsx_pkg::OP_LOAD};
		logic       dbl[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		logic [2:0] adr[4] = '{3'h2, 3'h1, 3'h4, 3'h4};
		logic       bad[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			run(mk(ops[i], dbl[i], 5'h07, 5'h00, adr[i], 4'h0));
			check("address error", 32'(a_aerr), 32'(bad[i]));
			repeat (4) @(posedge i_sys_clk);
		end
	endtask

	task automatic t_endian();
		big <= 1'b1;
		run(mk(fsx_pkg::OP_LOAD, 1'b0, 5'h03, 5'h00, 3'h0, 4'h0));
		check("big lane", 32'(a_lane), 32'(fsx_pkg::LANE_BIG));
		big <= 1'b0;
		run(mk(fsx_pkg::OP_LOAD, 1'b0, 5'h03, 5'h00, 3'h0, 4'h0));
		check("little lane", 32'(a_lane), 32'(fsx_pkg::LANE_LITTLE));
		run2(mk(fsx_pkg::OP_LOAD, 1'b0, 5'h04, 5'h00, 3'h0, 4'h0),
			mk(fsx_pkg::OP_ADD, 1'b0, 5'h05, 5'h04, 3'h0, 4'h0));
		check("load use order",
			32'(st_cyc - st_prev >= int'(fsx_pkg::LAT_LOAD)), 32'h1);
		repeat (8) @(posedge i_sys_clk);
		run2(mk(fsx_pkg::OP_ADD, 1'b0, 5'h06, 5'h00, 3'h0, 4'h0),
			mk(fsx_pkg::OP_STORE, 1'b0, 5'h00, 5'h06, 3'h0, 4'h0));
		check("pending read stall", 32'(stall_seen), 32'h1);
		check("pending read order",
			32'(st_cyc - st_prev >= int'(fsx_pkg::LAT_ADD)), 32'h1);
		repeat (8) @(posedge i_sys_clk);
	endtask

	task automatic t_move();
		mv_d <= 32'hA5C30F81;
		run(mk(fsx_pkg::OP_TO_FP, 1'b0, 5'h06, 5'h00, 3'h0, 4'h0));
		repeat (3) @(posedge i_sys_clk);
		check("move to fp", o_move_data, 32'hA5C30F81);
		check("move to fp trap", 32'(a_trap), 32'h0);
		mv_d <= 32'h5A3CF07E;
		run(mk(fsx_pkg::OP_FROM_FP, 1'b0, 5'h06, 5'h00, 3'h0, 4'h0));
		repeat (3) @(posedge i_sys_clk);
		check("move from fp", o_move_data, 32'h5A3CF07E);
	endtask

	task automatic t_cmp();
		fsx_pkg::fsx_iss_t w;
		logic [31:0] ca[4] = '{32'h7F800001, 32'h7F800001, 32'h80000000,
			32'h80000000};
		logic [31:0] cb[4] = '{32'h3F800000, 32'h3F800000, 32'h00000000,
			32'h00000000};
		logic [3:0]  cn[4] = '{4'h2, 4'h1, 4'h4, 4'h4};
		logic        wd[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		logic        ex[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		cmp_a <= 32'h3F800000;
		cmp_b <= 32'h40000000;
		for (int c = 0; c < 16; c++) begin
			run(mk(fsx_pkg::OP_CMP, 1'b0, 5'h00, 5'h00, 3'h0, 4'(c)));
			repeat (int'(fsx_pkg::LAT_CMP) + 3) @(posedge i_sys_clk);
			check("less predicate", 32'(o_cond), 32'((c >> 2) & 1));
		end
		cmp_b <= 32'h3F800000;
		run(mk(fsx_pkg::OP_CMP, 1'b0, 5'h00, 5'h00, 3'h0, 4'h2));
		repeat (int'(fsx_pkg::LAT_CMP) + 3) @(posedge i_sys_clk);
		check("equal predicate", 32'(o_cond), 32'h1);
		// quiet nan, signed zeros, then the same bits as words
		for (int i = 0; i < 4; i++) begin
			cmp_a <= ca[i];
			cmp_b <= cb[i];
			w = mk(fsx_pkg::OP_CMP, 1'b0, 5'h00, 5'h00, 3'h0, cn[i]);
			w.word_fmt = wd[i];
			run(w);
			repeat (int'(fsx_pkg::LAT_CMP) + 3) @(posedge i_sys_clk);
			check("cond bit", 32'(o_cond), 32'(ex[i]));
		end
	endtask

	task automatic t_exc();
		logic [4:0] en[5] = '{5'h00, 5'h08, 5'h00, 5'h00, 5'h00};
		logic       fl[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		logic [4:0] ev[5] = '{5'h10, 5'h08, 5'h02, 5'h02, 5'h00};
		logic       tr[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		logic [4:0] fg[5] = '{5'h10, 5'h10, 5'h10, 5'h12, 5'h12};
		for (int i = 0; i < 5; i++) begin
			enable <= en[i];
			flush <= fl[i];
			exc <= '{1'b1, ev[i], (i == 4)};
			@(posedge i_sys_clk);
			exc <= '0;
			@(posedge i_sys_clk);
			check("exception trap", 32'(o_trap), 32'(tr[i]));
			check("default result", 32'(o_commit), 32'(!tr[i]));
			check("quiet nan", 32'(o_qnan), 32'(i == 0));
			check("sticky flags", 32'(o_flags), 32'(fg[i]));
			check("cause bits", 32'(o_cause),
				{26'h0, tr[i] && !(|(ev[i] & en[i])), ev[i]});
		end
		repeat (5) @(posedge i_sys_clk);
		check("flags held", 32'(o_flags), 32'h12);
		for (int i = 0; i < 2; i++) begin
			flag_d <= (i == 0) ? 5'h00 : 5'h03;
			flag_wr <= 1'b1;
			@(posedge i_sys_clk);
			flag_wr <= 1'b0;
			@(posedge i_sys_clk);
			check("flag write", 32'(o_flags), (i == 0) ? 32'h0 : 32'h3);
		end
	endtask

	initial begin
		i_arst_n = 1'b0;
		go = 1'b0;
		cmd = '0;
		mv_d = 32'h0;
		cmp_a = 32'h0;
		cmp_b = 32'h0;
		exc = '0;
		enable = 5'h00;
		flush = 1'b0;
		big = 1'b0;
		flag_wr = 1'b0;
		flag_d = 5'h00;
		repeat (16) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		@(posedge i_sys_clk);
		t_lat();
		t_pair();
		t_dbl();
		t_align();
		t_endian();
		t_move();
		t_cmp();
		t_exc();
		report_and_stop();
	end
endmodule // tb_fsx_sched
